// File: logic/mcd_pkg.sv
/*
  Constants and types of the instruction decoder: opcode patterns, the
  decoded-operation carrier, the register map and the bus carriers.
  Assumes a single clock domain and 16-bit instruction words.
*/
package mcd_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam int AXI_AW = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] ICNT_OFS = 4'h8;
  localparam int CTRL_HALT_BIT = 0;
  localparam logic HALT_RST = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Special register addresses in the access bank
  localparam logic [7:0] PORT_LO = 8'h80;
  localparam logic [7:0] PORT_HI = 8'h84;
  localparam logic [7:0] TIMER_ZERO_ADDR = 8'hc0;
  // ==========================================================
  // Opcode patterns
  localparam logic [3:0] NIB_LIT = 4'h0;
  localparam logic [3:0] NIB_TGL = 4'h7;
  localparam logic [3:0] NIB_BSET = 4'h8;
  localparam logic [3:0] NIB_BCLR = 4'h9;
  localparam logic [3:0] NIB_SKSET = 4'ha;
  localparam logic [3:0] NIB_SKCLR = 4'hb;
  localparam logic [3:0] NIB_REL = 4'hd;
  localparam logic [3:0] NIB_CTL = 4'he;
  localparam logic [3:0] NIB_OPND = 4'hf;
  localparam logic [6:0] CALL_HI = 7'h76;
  localparam logic [7:0] PTR_HI = 8'hee;
  localparam logic [7:0] JUMP_HI = 8'hef;
  localparam logic [3:0] LN_CTRL = 4'h0;
  localparam logic [3:0] LN_BANK = 4'h1;
  localparam logic [3:0] LN_SUB = 4'h8;
  localparam logic [3:0] LN_OR = 4'h9;
  localparam logic [3:0] LN_XOR = 4'ha;
  localparam logic [3:0] LN_AND = 4'hb;
  localparam logic [3:0] LN_RETL = 4'hc;
  localparam logic [3:0] LN_MUL = 4'hd;
  localparam logic [3:0] LN_MOVW = 4'he;
  localparam logic [3:0] LN_ADD = 4'hf;
  localparam logic [7:0] W_NOP = 8'h00;
  localparam logic [7:0] W_SLEEP = 8'h03;
  localparam logic [7:0] W_WDT = 8'h04;
  localparam logic [7:0] W_PUSH = 8'h05;
  localparam logic [7:0] W_POP = 8'h06;
  localparam logic [7:0] W_DAW = 8'h07;
  localparam logic [7:0] W_RST = 8'hff;
  localparam logic [5:0] W_PROGRAM_TABLE_READ_OP = 6'h02;
  localparam logic [5:0] W_PROGRAM_TABLE_WRITE_OP = 6'h03;
  localparam logic [6:0] W_IRET = 7'h08;
  localparam logic [6:0] W_SRET = 7'h09;
  // ==========================================================
  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    nop_op, bit_clear_op, bit_set_op, skip_if_bit_clear_op, skip_if_bit_set_op,
    bit_toggle_op, branch_cond_op, branch_always_op, relative_subroutine_op,
    absolute_call_op, absolute_jump_op, watchdog_clear_op, standby_op, pop_op,
    push_op, soft_reset_op, interrupt_return_op, subroutine_return_op,
    literal_return_op, decimal_adjust_op, add_immediate_op,
    subtract_from_immediate_op, and_immediate_op, or_immediate_op,
    xor_immediate_op, accumulator_load_op, multiply_immediate_op,
    bank_load_op, pointer_load_op, program_table_read_op, program_table_write_op
  } mcd_op_t;
  typedef enum {ST_EXEC, ST_SECOND, ST_FLUSH, ST_SKIP, ST_SKIP2, ST_TBL, ST_SLEEP} mcd_st_t;
  typedef struct packed {logic c, dc, z, ov, n;} mcd_flags_t;
  typedef struct packed {
    mcd_op_t op; logic [2:0] cond; logic [2:0] bit_pos; logic bank;
    logic [7:0] faddr; logic [7:0] lit; logic [11:0] ptr_lit; logic [1:0] ptr_sel;
    logic [1:0] tbl_mode; logic [19:0] target; logic fast; logic pc_change;
    logic skip; mcd_flags_t flags_upd; logic tp_upd; logic irq_reen;
    logic all_upd; logic [1:0] cycles;
  } mcd_dec_t;
  typedef struct packed {
    logic [AXI_AW-1:0] awaddr; logic awvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic wvalid; logic bready;
    logic [AXI_AW-1:0] araddr; logic arvalid; logic rready;
  } mcd_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic [1:0] bresp; logic bvalid;
    logic arready; logic [31:0] rdata; logic [1:0] rresp; logic rvalid;
  } mcd_axi_rsp_t;
  typedef struct packed {
    logic [21:0] pad; logic halt; logic sleep; logic [2:0] st; mcd_op_t op;
  } mcd_stat_t;
endpackage

// File: logic/mcd_decoder.sv
/*
  Instruction decoder and sequencer for the bit, control, literal and
  table groups, with an AXI4-Lite control/status slave.
  Assumes program memory presents one word per cycle with its word address,
  and the datapath supplies flags and the addressed register's data.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - skip-if-clear test, one to three cycles
// - skip-if-set test, same timing
// - conditional branches, taken costs two cycles
// - branch always and relative call, two cycles
// - absolute call two words, fast save bit
// - absolute jump two words, two cycles
// - watchdog clear updates timeout and powerdown
// - standby updates timeout and powerdown flags
// - pop and push return stack, one cycle
// - software reset, one cycle, all status
// - interrupt return, two cycles, reenable interrupts
// - subroutine and literal return, two cycles
// - literal arithmetic and logic flag updates
// - accumulator load, multiply, flags kept
// - bank load writes low four bits
// - pointer load two words, twelve-bit literal
// - table read/write with pointer mode, two cycles
// - program counter change adds nop cycle, except for the two-word call and jump
// - lone operand word executes as nop
// - port targets read pin values
// - timer write clears assigned prescaler
module mcd_decoder import mcd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  output logic o_fetch_ready,
  input wire logic [19:0] i_pc,
  input wire mcd_flags_t i_flags,
  input wire logic [7:0] i_latch_data,
  input wire logic [7:0] i_pin_data,
  input wire logic i_presc_on_timer,
  input wire logic i_wake,
  output mcd_dec_t o_dec,
  output logic o_dec_valid,
  output logic o_nop_cycle,
  output logic o_presc_clr,
  output logic [7:0] o_src_data,
  input wire mcd_axi_req_t i_axi,
  output mcd_axi_rsp_t o_axi
);
  // ==========================================================
  // State
  typedef struct packed {
    mcd_st_t st;
    mcd_dec_t dec;
    mcd_dec_t held;
    logic dvld;
    logic nop;
    logic pclr;
    logic [7:0] src;
    logic halt;
    logic [15:0] icnt;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcd_state_t;

  mcd_state_t s_reg; // Registered state
  mcd_state_t s_next; // Next state
  logic take; // Word accepted this cycle
  logic acc_exec; // First word accepted
  logic [7:0] src_sel; // Source byte of a bit operation
  logic bit_val; // Selected bit of the source byte
  mcd_stat_t stat; // Status word

  // ==========================================================
  // Decoding helpers
  // Access-bank port register targeted
  function automatic logic port_hit(input logic [15:0] w);
    port_hit = !w[8] && w[7:0] >= PORT_LO && w[7:0] <= PORT_HI;
  endfunction

  // First word of a two-word instruction
  function automatic logic two_word(input logic [15:0] w);
    two_word = w[15:9] == CALL_HI || w[15:8] == JUMP_HI ||
               (w[15:8] == PTR_HI && w[7:6] == 2'h0);
  endfunction

  // Branch condition: zero, carry, overflow, negative; low bit inverts
  function automatic logic cond_true(input logic [2:0] cc, input mcd_flags_t f);
    logic v;
    case (cc[2:1])
      2'h0: v = f.z;
      2'h1: v = f.c;
      2'h2: v = f.ov;
      default: v = f.n;
    endcase
    cond_true = v ^ cc[0];
  endfunction

  // Register decode shared by read and write
  function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
    reg_hit = a == CTRL_OFS || a == STAT_OFS || a == ICNT_OFS;
  endfunction

  // ==========================================================
  // Fetch handshake
  // Word taken unless stalled by table access, standby or halt
  assign o_fetch_ready = !s_reg.halt && s_reg.st != ST_TBL && s_reg.st != ST_SLEEP;
  assign take = i_instr_valid && o_fetch_ready;
  assign acc_exec = take && s_reg.st == ST_EXEC;
  assign src_sel = port_hit(i_instr) ? i_pin_data : i_latch_data;
  assign bit_val = src_sel[i_instr[11:9]];
  assign stat = '{pad: 22'h0, halt: s_reg.halt, sleep: s_reg.st == ST_SLEEP,
                  st: 3'(s_reg.st), op: s_reg.dec.op};

  // ==========================================================
  // Next-state logic
  always_comb begin
    mcd_dec_t d;
    logic [15:0] w;
    d = '0;
    w = i_instr;
    s_next = s_reg;
    s_next.dvld = 1'b0;
    s_next.nop = 1'b0;
    s_next.pclr = 1'b0;
    // Common field extraction
    d.op = nop_op;
    d.cycles = CYC_ONE;
    d.bit_pos = w[11:9];
    d.bank = w[8];
    d.faddr = w[7:0];
    d.lit = w[7:0];
    d.fast = w[0];
    d.cond = w[10:8];
    d.tbl_mode = w[1:0];
    d.ptr_sel = w[5:4];
    d.ptr_lit = {w[3:0], 8'h00};
    case (s_reg.st)
      // Decode a first word
      ST_EXEC: begin
        if (take) begin
          s_next.dvld = 1'b1;
          s_next.src = src_sel;
          case (w[15:12])
            NIB_BCLR: d.op = bit_clear_op;
            NIB_BSET: d.op = bit_set_op;
            NIB_TGL: d.op = bit_toggle_op;
            NIB_SKCLR, NIB_SKSET: begin
              d.op = w[12] ? skip_if_bit_clear_op : skip_if_bit_set_op;
              // Skip when tested bit matches
              if (bit_val != w[12]) begin
                d.skip = 1'b1;
                d.cycles = CYC_TWO;
                s_next.st = ST_SKIP;
              end
            end
            NIB_REL: begin
              d.op = w[11] ? relative_subroutine_op : branch_always_op;
              d.target = i_pc + 20'h1 + {{9{w[10]}}, w[10:0]};
              d.pc_change = 1'b1;
              d.cycles = CYC_TWO;
              s_next.st = ST_FLUSH;
            end
            NIB_CTL: begin
              if (!w[11]) begin
                d.op = branch_cond_op;
                d.target = i_pc + 20'h1 + {{12{w[7]}}, w[7:0]};
                // Taken branch adds a flush cycle
                if (cond_true(w[10:8], i_flags)) begin
                  d.pc_change = 1'b1;
                  d.cycles = CYC_TWO;
                  s_next.st = ST_FLUSH;
                end
              end else if (two_word(w)) begin
                // Hold first word until the operand arrives
                d.op = w[15:9] == CALL_HI ? absolute_call_op :
                       (w[8] ? absolute_jump_op : pointer_load_op);
                d.target = {12'h000, w[7:0]};
                // Call save bit sits just above the address byte
                d.fast = w[15:9] == CALL_HI && w[8];
                d.cycles = CYC_TWO;
                s_next.dvld = 1'b0;
                s_next.held = d;
                s_next.st = ST_SECOND;
              end
            end
            NIB_OPND: begin
              s_next.dvld = 1'b0;
              s_next.nop = 1'b1;
            end
            NIB_LIT: begin
              case (w[11:8])
                LN_ADD, LN_SUB: begin
                  d.op = w[10] ? add_immediate_op : subtract_from_immediate_op;
                  d.flags_upd = 5'h1f;
                end
                LN_AND: begin
                  d.op = and_immediate_op;
                  d.flags_upd = 5'h05;
                end
                LN_OR: begin
                  d.op = or_immediate_op;
                  d.flags_upd = 5'h05;
                end
                LN_XOR: begin
                  d.op = xor_immediate_op;
                  d.flags_upd = 5'h05;
                end
                LN_MOVW: d.op = accumulator_load_op;
                LN_MUL: d.op = multiply_immediate_op;
                LN_RETL: begin
                  d.op = literal_return_op;
                  d.pc_change = 1'b1;
                  d.cycles = CYC_TWO;
                  s_next.st = ST_FLUSH;
                end
                LN_BANK: begin
                  // Only the low nibble reaches the bank select
                  if (w[7:4] == 4'h0) begin
                    d.op = bank_load_op;
                    d.lit = {4'h0, w[3:0]};
                  end
                end
                LN_CTRL: begin
                  if (w[7:2] == W_PROGRAM_TABLE_READ_OP || w[7:2] == W_PROGRAM_TABLE_WRITE_OP) begin
                    d.op = w[2] ? program_table_write_op : program_table_read_op;
                    d.cycles = CYC_TWO;
                    s_next.st = ST_TBL;
                  end else if (w[7:1] == W_IRET || w[7:1] == W_SRET) begin
                    d.op = w[1] ? subroutine_return_op : interrupt_return_op;
                    d.irq_reen = !w[1];
                    d.pc_change = 1'b1;
                    d.cycles = CYC_TWO;
                    s_next.st = ST_FLUSH;
                  end else begin
                    case (w[7:0])
                      W_WDT: begin
                        d.op = watchdog_clear_op;
                        d.tp_upd = 1'b1;
                      end
                      W_SLEEP: begin
                        d.op = standby_op;
                        d.tp_upd = 1'b1;
                        s_next.st = ST_SLEEP;
                      end
                      W_POP: d.op = pop_op;
                      W_PUSH: d.op = push_op;
                      W_DAW: begin
                        d.op = decimal_adjust_op;
                        d.flags_upd = 5'h10;
                      end
                      W_RST: begin
                        d.op = soft_reset_op;
                        d.all_upd = 1'b1;
                        s_next.icnt = 16'h0;
                      end
                      W_NOP: d.op = nop_op;
                      default: d.op = nop_op;
                    endcase
                  end
                end
                default: d.op = nop_op;
              endcase
            end
            default: d.op = nop_op;
          endcase
          // Prescaler clear on bit write to timer
          if ((w[15:12] == NIB_BCLR || w[15:12] == NIB_BSET || w[15:12] == NIB_TGL) &&
              !w[8] && w[7:0] == TIMER_ZERO_ADDR && i_presc_on_timer) begin
            s_next.pclr = 1'b1;
          end
          if (s_next.dvld) begin
            s_next.dec = d;
          end
        end
      end
      // Operand word completes the held instruction
      ST_SECOND: begin
        if (take) begin
          d = s_reg.held;
          d.target = {w[11:0], s_reg.held.target[7:0]};
          d.ptr_lit = {s_reg.held.ptr_lit[11:8], w[7:0]};
          d.pc_change = s_reg.held.op != pointer_load_op;
          s_next.dec = d;
          s_next.dvld = 1'b1;
          s_next.st = ST_EXEC;
        end
      end
      // Prefetched word discarded
      ST_FLUSH: begin
        if (take) begin
          s_next.nop = 1'b1;
          s_next.st = ST_EXEC;
        end
      end
      // Skipped word; a two-word one costs a third cycle
      ST_SKIP: begin
        if (take) begin
          s_next.nop = 1'b1;
          s_next.st = two_word(w) ? ST_SKIP2 : ST_EXEC;
        end
      end
      ST_SKIP2: begin
        if (take) begin
          s_next.nop = 1'b1;
          s_next.st = ST_EXEC;
        end
      end
      // Table access second cycle
      ST_TBL: begin
        s_next.nop = 1'b1;
        s_next.st = ST_EXEC;
      end
      // Standby until woken
      ST_SLEEP: begin
        if (i_wake) begin
          s_next.st = ST_EXEC;
        end
      end
      default: s_next.st = ST_EXEC;
    endcase
    if (s_next.dvld) begin
      s_next.icnt = s_next.icnt + 16'h1;
    end
    // Bus write channels
    if (s_reg.bvalid && i_axi.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (i_axi.awvalid && o_axi.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = i_axi.awaddr;
    end
    if (i_axi.wvalid && o_axi.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = i_axi.wdata;
      s_next.wstrb = i_axi.wstrb;
    end
    if (s_next.aw_got && s_next.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = reg_hit(s_next.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_next.awaddr == CTRL_OFS && s_next.wstrb[0]) begin
        s_next.halt = s_next.wdata[CTRL_HALT_BIT];
      end
    end
    // Bus read channel
    if (s_reg.rvalid && i_axi.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (i_axi.arvalid && o_axi.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = reg_hit(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
      case (i_axi.araddr)
        CTRL_OFS: s_next.rdata = {31'h0, s_reg.halt};
        STAT_OFS: s_next.rdata = stat;
        ICNT_OFS: s_next.rdata = {16'h0, s_reg.icnt};
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign o_dec = s_reg.dec;
  assign o_dec_valid = s_reg.dvld;
  assign o_nop_cycle = s_reg.nop;
  assign o_presc_clr = s_reg.pclr;
  assign o_src_data = s_reg.src;
  assign o_axi.awready = !s_reg.aw_got && !s_reg.bvalid;
  assign o_axi.wready = !s_reg.w_got && !s_reg.bvalid;
  assign o_axi.bvalid = s_reg.bvalid;
  assign o_axi.bresp = s_reg.bresp;
  assign o_axi.arready = !s_reg.rvalid;
  assign o_axi.rvalid = s_reg.rvalid;
  assign o_axi.rdata = s_reg.rdata;
  assign o_axi.rresp = s_reg.rresp;

  // ==========================================================
  // Assertions
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_BIT_CLR: assert property (acc_exec && i_instr[15:12] == NIB_BCLR |=> o_dec_valid &&
    o_dec.op == bit_clear_op && o_dec.flags_upd == 5'h0 && o_dec.bit_pos == $past(i_instr[11:9]))
    else $error("bit clear not decoded");
  AST_SKIP_CLR: assert property (acc_exec && i_instr[15:12] == NIB_SKCLR && !bit_val |=>
    s_reg.st == ST_SKIP && o_dec.skip) else $error("skip on clear bit missed");
  AST_SKIP_SET: assert property (acc_exec && i_instr[15:12] == NIB_SKSET && !bit_val |=>
    !o_dec.skip && s_reg.st == ST_EXEC) else $error("skip taken on clear bit");
  AST_SKIP_THIRD: assert property (s_reg.st == ST_SKIP && take && two_word(i_instr) |=>
    o_nop_cycle && s_reg.st == ST_SKIP2) else $error("two-word skip lacks third cycle");
  AST_BR_COND: assert property (o_dec_valid && o_dec.op == branch_cond_op |->
    o_dec.pc_change == (s_reg.st == ST_FLUSH)) else $error("branch flush mismatch");
  AST_BRA: assert property (acc_exec && i_instr[15:11] == 5'h1a |=> o_dec.pc_change &&
    o_dec.target == 20'($past(i_pc) + 20'h1 + {{9{$past(i_instr[10])}}, $past(i_instr[10:0])}))
    else $error("branch target wrong");
  AST_TWO_WORD: assert property (acc_exec && two_word(i_instr) |=> s_reg.st == ST_SECOND &&
    !o_dec_valid) else $error("first word not held");
  AST_JUMP_TGT: assert property (s_reg.st == ST_SECOND && take && s_reg.held.op == absolute_jump_op
    |=> o_dec_valid && o_dec.target[19:8] == $past(i_instr[11:0])) else $error("jump target wrong");
  AST_FLUSH: assert property (s_reg.st == ST_FLUSH && take |=> o_nop_cycle && !o_dec_valid &&
    s_reg.st == ST_EXEC) else $error("flush cycle not a nop");
  AST_STRAY: assert property (acc_exec && i_instr[15:12] == NIB_OPND |=> o_nop_cycle &&
    !o_dec_valid) else $error("operand word executed");
  AST_TBL: assert property (acc_exec && i_instr[15:3] == 13'h0001 |=> !o_fetch_ready ##1
    o_nop_cycle) else $error("table op not two cycles");
  AST_PINS: assert property (acc_exec && port_hit(i_instr) |=> o_src_data == $past(i_pin_data))
    else $error("port source not pins");
  AST_PRESC: assert property (o_presc_clr |-> $past(acc_exec) && $past(i_presc_on_timer))
    else $error("spurious prescaler clear");
  AST_CALL_FAST: assert property (acc_exec && i_instr[15:9] == CALL_HI |=>
    s_reg.held.fast == $past(i_instr[8])) else $error("call save bit wrong");
  AST_LOGIC_FLAGS: assert property (acc_exec && i_instr[15:12] == NIB_LIT && (i_instr[11:8] == LN_AND ||
    i_instr[11:8] == LN_OR || i_instr[11:8] == LN_XOR) |=> o_dec.flags_upd.z && o_dec.flags_upd.n &&
    !o_dec.flags_upd.c && !o_dec.flags_upd.dc && !o_dec.flags_upd.ov) else $error("logic flag set wrong");
endmodule
`default_nettype wire

// File: verification/mcd_prog_mem.sv
/*
  Program memory model that feeds the decoder one word per fetch.
  Assumes the bench fills mem while i_rst is high.
*/
`timescale 1ns/10ps
`default_nettype none
module mcd_prog_mem (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ready,
  output logic [15:0] o_instr,
  output logic o_valid,
  output logic [19:0] o_pc
);
  logic [15:0] mem [0:31]; // Program words
  // Word held until taken; it is inverted while not offered
  assign o_instr = o_valid ? mem[o_pc[4:0]] : ~mem[o_pc[4:0]];
  // Word address advances at each taking edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pc <= 20'h0;
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b1;
      if (o_valid && i_ready) o_pc <= o_pc + 20'h1;
    end
  end
endmodule
`default_nettype wire

// File: verification/test_mcd_decoder.sv
/*
  Bench for the decoder: runs short programs and checks decode order,
  NOP cycles, source choice, standby, halt and the register bus.
  Assumes the mcd_prog_mem model as the program memory.
*/
`timescale 1ns/10ps
`default_nettype none
module test_mcd_decoder import mcd_pkg::*;;
  logic i_clk = 0, rst = 1, mrst = 1, ready, valid, wake = 0, presc = 0, dv, nc, pclr;
  logic [15:0] instr;
  logic [19:0] pc;
  logic [7:0] latch = 8'h0, pins = 8'h0, src;
  logic [31:0] d;
  logic [1:0] r;
  mcd_flags_t flags = 5'h04; // Zero flag set
  mcd_dec_t dec;
  mcd_axi_req_t ax = '0;
  mcd_axi_rsp_t rs;
  logic [7:0] log_q[$]; // Op with prescaler clear in bit 7, or ff for a NOP cycle
  int errors = 0, checked = 0;
  always #50 i_clk = ~i_clk;
  mcd_prog_mem pm (.i_clk(i_clk), .i_rst(mrst), .i_ready(ready), .o_instr(instr), .o_valid(valid), .o_pc(pc));
  mcd_decoder DUT (.i_clk(i_clk), .i_sys_rst(rst), .i_instr(instr), .i_instr_valid(valid), .o_fetch_ready(ready),
    .i_pc(pc), .i_flags(flags), .i_latch_data(latch), .i_pin_data(pins), .i_presc_on_timer(presc), .i_wake(wake),
    .o_dec(dec), .o_dec_valid(dv), .o_nop_cycle(nc), .o_presc_clr(pclr), .o_src_data(src), .i_axi(ax), .o_axi(rs));
  // Logs every executed instruction
  always @(posedge i_clk) begin
    if (dv) log_q.push_back({pclr, 2'h0, dec.op});
    else if (nc) log_q.push_back(8'hff);
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Loads a program, lets it run and compares the log
  task automatic run(input logic [15:0] p[$], input logic [7:0] e[$]);
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < 32; i++) pm.mem[i] = (i < p.size()) ? p[i] : 16'h0;
    log_q = {};
    mrst <= 1'b0;
    repeat (e.size() + 6) @(posedge i_clk);
    for (int i = 0; i < e.size(); i++) chk("op", log_q[i], e[i]);
    mrst <= 1'b1;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    ax.awaddr <= a;
    ax.wdata <= wd;
    ax.wstrb <= 4'hf;
    ax.awvalid <= 1'b1;
    ax.wvalid <= 1'b1;
    ax.bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (rs.awready) ax.awvalid <= 1'b0;
      if (rs.wready) ax.wvalid <= 1'b0;
    end while (!rs.bvalid);
    ax.bready <= 1'b0;
    r = rs.bresp;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge i_clk);
    ax.araddr <= a;
    ax.arvalid <= 1'b1;
    ax.rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (rs.arready) ax.arvalid <= 1'b0;
    end while (!rs.rvalid);
    ax.rready <= 1'b0;
    d = rs.rdata;
    r = rs.rresp;
  endtask
  task automatic t_flow;
    run('{16'h8301, 16'h9301, 16'h7301, 16'he005, 16'h0000, 16'hf123, 16'he105, 16'hef12, 16'hf345, 16'h0012,
      16'h0000, 16'h0009}, '{8'h02, 8'h01, 8'h05, 8'h06, 8'hff, 8'hff, 8'h06, 8'h0a, 8'h11, 8'hff, 8'h1d,
      8'hff});
    $display("flow done");
  endtask
  task automatic t_ctl;
    run('{16'h0004, 16'h0006, 16'h0005, 16'h0007, 16'h0f01, 16'h0801, 16'h0b01, 16'h0901, 16'h0a01, 16'h0e01,
      16'h0d01, 16'h0105, 16'h0c01, 16'h0000, 16'hd805, 16'h0000, 16'h0011, 16'h0000, 16'h0002, 16'he800,
      16'hec01, 16'hf000, 16'hee12, 16'hf034, 16'hd000}, '{8'h0b, 8'h0d, 8'h0e, 8'h13, 8'h14, 8'h15, 8'h16,
      8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h12, 8'hff, 8'h08, 8'hff, 8'h10, 8'hff, 8'h00, 8'h00, 8'h09,
      8'h1c, 8'h07, 8'hff});
    $display("control done");
  endtask
  task automatic t_skip;
    latch <= 8'h00;
    run('{16'hb301, 16'hef00, 16'hf000, 16'ha301, 16'h8301}, '{8'h03, 8'hff, 8'hff, 8'h04, 8'h02});
    $display("skip done");
  endtask
  task automatic t_src;
    latch <= 8'ha5;
    pins <= 8'h5a;
    presc <= 1'b1;
    // Every word up to the stop after the first, which targets the timer, targets a port, so the source byte ends as the pin value
    run('{16'h80c0, 16'h7081, 16'h7081, 16'h7081, 16'h7081, 16'h7081, 16'h7081, 16'h7081,
      16'h7081}, '{8'h82, 8'h05});
    @(negedge i_clk);
    chk("src", src, 8'h5a);
    $display("source done");
  endtask
  task automatic t_sleep;
    run('{16'h00ff, 16'h0003}, '{8'h0f, 8'h0c});
    chk("ready", ready, 1'b0);
    wake <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("ready", ready, 1'b1);
    wake <= 1'b0;
    $display("standby done");
  endtask
  task automatic t_halt;
    axw(CTRL_OFS, 32'h1);
    chk("bresp", r, RESP_OKAY);
    @(posedge i_clk);
    chk("ready", ready, 1'b0);
    axr(STAT_OFS);
    chk("halt", d[9], 1'b1);
    axr(4'hc);
    chk("rresp", r, RESP_SLVERR);
    chk("rdata", d, 32'h0);
    // Soft reset cleared the count; it and the standby word were decoded since
    axr(ICNT_OFS);
    chk("icnt", d, 32'h2);
    axw(CTRL_OFS, 32'h0);
    @(posedge i_clk);
    chk("ready", ready, 1'b1);
    $display("bus done");
  endtask
  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    rst <= 1'b0;
    t_flow;
    t_ctl;
    t_skip;
    t_src;
    t_sleep;
    t_halt;
    wrap_up;
  end
  // Cuts a hang short
  initial begin
    repeat (3000) @(posedge i_clk);
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
